/* design/cju_pkg.sv */
// Shared constants of the conditional jump unit
package cju_pkg;

  // Datapath widths
  localparam int PC_W     = 20;  // Program counter width
  localparam int OFS_W    = 10;  // Signed word offset width
  localparam int SW_W     = 16;  // Status word width
  localparam int AXI_AW   = 8;   // Register bus address width
  localparam int AXI_DW   = 32;  // Register bus data width

  // Status word bit positions
  localparam int SW_C_BIT      = 0;  // Carry flag
  localparam int SW_Z_BIT      = 1;  // Zero flag
  localparam int SW_N_BIT      = 2;  // Negative flag
  localparam int SW_GIE_BIT    = 3;  // global_irq_enable mode bit
  localparam int SW_CPU_OFF_BIT_BIT = 4;  // cpu_off_bit mode bit
  localparam int SW_OSCILLATOR_OFF_BIT_BIT = 5;  // oscillator_off_bit mode bit
  localparam int SW_V_BIT      = 8;  // Overflow flag

  // Reset values
  localparam logic [SW_W-1:0] SW_RESET   = 16'h0000;  // Status word after reset
  localparam logic [PC_W-1:0] PC_RESET   = 20'h00000; // Target register after reset
  localparam logic [1:0]      CTRL_RESET = 2'h1;      // Counting enabled after reset

  // Register byte offsets
  localparam logic [AXI_AW-1:0] REG_CTRL   = 8'h00;  // Control
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;  // Status word, read only
  localparam logic [AXI_AW-1:0] REG_TARGET = 8'h08;  // Last resolved target, read only
  localparam logic [AXI_AW-1:0] REG_TAKEN  = 8'h0c;  // Taken jump count, read only

  // Control fields
  localparam int CTRL_COUNT_EN_BIT = 0;  // Count taken jumps
  localparam int CTRL_CLEAR_BIT    = 1;  // Write 1 to clear the count

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;  // Accepted
  localparam logic [1:0] RESP_SLVERR = 2'h2;  // Unmapped address

  // Jump kinds as delivered by decode
  typedef enum logic [2:0] {
    jump_on_carry,               // Also unsigned higher-or-same
    jump_on_zero,                // Also equal
    jump_signed_ge,              // Also jump_if_positive after V clear
    jump_signed_lt,
    jump_on_negative,
    jump_always
  } cju_kind_t;

endpackage : cju_pkg

/* design/cju_resolve.sv */
`timescale 1ns/100ps
`default_nettype none
// Branch decision and relative target for one jump
module cju_resolve
  import cju_pkg::*;
(
  input  wire logic [2:0]      kind,       // Jump kind
  input  wire logic [SW_W-1:0] flags,      // Current status word
  input  wire logic [PC_W-1:0] pc_next,    // Address of word after the jump
  input  wire logic [OFS_W-1:0] offset,    // Signed word offset
  output logic                 taken,      // Branch is taken
  output logic [PC_W-1:0]      target      // Branch target
);

  // Flag taps
  wire logic flag_c = flags[SW_C_BIT];  // Carry
  wire logic flag_z = flags[SW_Z_BIT];  // Zero
  wire logic flag_n = flags[SW_N_BIT];  // Negative
  wire logic flag_v = flags[SW_V_BIT];  // Overflow

  // Offset doubled then sign extended to the full counter width
  wire logic [OFS_W:0]  ofs_x2  = {offset, 1'b0};
  wire logic [PC_W-1:0] ofs_ext = {{(PC_W-OFS_W-1){offset[OFS_W-1]}}, ofs_x2};

  // Modulo add, so targets wrap across both ends of the address space
  assign target = pc_next + ofs_ext;

  // Condition selection per kind
  always_comb begin
    case (cju_kind_t'(kind))
      jump_on_carry:    taken = flag_c;
      jump_on_zero:     taken = flag_z;
      jump_signed_ge:   taken = ~(flag_n ^ flag_v);
      jump_signed_lt:   taken = flag_n ^ flag_v;
      jump_on_negative: taken = flag_n;
      jump_always:      taken = 1'b1;
      default:          taken = 1'b0;                // Unknown kind falls through
    endcase
  end

endmodule : cju_resolve
`default_nettype wire

/* design/cju_top.sv */
// Behaviour
// - Carry jump branches when carry is set
// - Zero jump branches when zero is set
// - Signed ge branches when N equals V
// - Signed lt branches when N differs V
// - Negative jump branches when N is set
// - Unconditional jump always loads relative target
// - Target is PC plus doubled sign-extended offset
// - Reach -512..+511 words, whole address space
// - Jumps never change C, Z, N, V
// - Jumps never change oscillator, cpu, irq bits
// - AND/BIT/rotate/sign-extend/test clear V
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module cju_top
  import cju_pkg::*;
(
  input  wire logic              ref_clk,        // 125 MHz clock
  input  wire logic              rst,            // Async reset, active high
  // Jump request from decode
  input  wire logic              jump_valid,     // One-cycle jump request
  input  wire logic [2:0]        jump_kind,      // Jump kind code
  input  wire logic [OFS_W-1:0]  jump_offset,    // Signed word offset
  input  wire logic [PC_W-1:0]   jump_pc_next,   // Address of word after jump
  // Resolution to fetch
  output logic                   pc_load,        // Pulse: load pc_value
  output logic [PC_W-1:0]        pc_value,       // New program counter
  output logic                   jump_done,      // Pulse: jump resolved
  output logic                   jump_taken,     // Branch decision of jump_done
  // Status word update from the arithmetic unit
  input  wire logic              sw_we,          // Status word write strobe
  input  wire logic [SW_W-1:0]   sw_wdata,       // Status word from the ALU
  input  wire logic              sw_op_clears_v, // Write comes from a V-clearing op
  output logic [SW_W-1:0]        status_word,    // Current status word
  // AXI4-Lite slave
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,   // Write address
  input  wire logic              s_axi_awvalid,  // Write address valid
  output logic                   s_axi_awready,  // Write address ready
  input  wire logic [AXI_DW-1:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]        s_axi_wstrb,    // Write byte enables
  input  wire logic              s_axi_wvalid,   // Write data valid
  output logic                   s_axi_wready,   // Write data ready
  output logic [1:0]             s_axi_bresp,    // Write response
  output logic                   s_axi_bvalid,   // Write response valid
  input  wire logic              s_axi_bready,   // Write response ready
  input  wire logic [AXI_AW-1:0] s_axi_araddr,   // Read address
  input  wire logic              s_axi_arvalid,  // Read address valid
  output logic                   s_axi_arready,  // Read address ready
  output logic [AXI_DW-1:0]      s_axi_rdata,    // Read data
  output logic [1:0]             s_axi_rresp,    // Read response
  output logic                   s_axi_rvalid,   // Read data valid
  input  wire logic              s_axi_rready    // Read data ready
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [SW_W-1:0]   sw_reg;          // Status word
  logic [SW_W-1:0]   sw_next;         // Status word next value
  logic              pc_load_reg;     // Load pulse
  logic [PC_W-1:0]   pc_value_reg;    // Last resolved target
  logic              done_reg;        // Resolved pulse
  logic              taken_reg;       // Last decision
  logic [1:0]        ctrl_reg;        // Control bits
  logic [AXI_DW-1:0] taken_cnt_reg;   // Taken jump count
  logic [AXI_DW-1:0] taken_cnt_next;  // Count next value
  logic              ctrl_clear;      // Count clear strobe from a control write

  // Bus slave state
  logic              aw_hold_reg;     // Write address captured
  logic [AXI_AW-1:0] aw_addr_reg;     // Captured write address
  logic              w_hold_reg;      // Write data captured
  logic [AXI_DW-1:0] w_data_reg;      // Captured write data
  logic [3:0]        w_strb_reg;      // Captured byte enables
  logic              bvalid_reg;      // Response pending
  logic [1:0]        bresp_reg;       // Response code
  logic              rvalid_reg;      // Read data pending
  logic [AXI_DW-1:0] rdata_reg;       // Read data
  logic [1:0]        rresp_reg;       // Read response code

  // ---------------------------------------------------------------
  // Branch resolution
  // ---------------------------------------------------------------
  logic            res_taken;   // Decision from the resolver
  logic [PC_W-1:0] res_target;  // Target from the resolver

  // Decision and target from the live status word
  cju_resolve u_resolve (
    .kind    (jump_kind),
    .flags   (sw_reg),
    .pc_next (jump_pc_next),
    .offset  (jump_offset),
    .taken   (res_taken),
    .target  (res_target)
  );

  // Fall-through keeps the address after the jump, so fetch just goes on
  wire logic [PC_W-1:0] pc_chosen = res_taken ? res_target : jump_pc_next;
  wire logic            take_now  = jump_valid & res_taken;                 // Branch this cycle

  // Registered resolution outputs, one cycle after the request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc_load_reg  <= 1'b0;
      pc_value_reg <= PC_RESET;
      done_reg     <= 1'b0;
      taken_reg    <= 1'b0;
    end else begin
      pc_load_reg <= take_now;
      done_reg    <= jump_valid;
      if (jump_valid) begin
        pc_value_reg <= pc_chosen;
        taken_reg    <= res_taken;
      end
    end
  end

  assign pc_load    = pc_load_reg;
  assign pc_value   = pc_value_reg;
  assign jump_done  = done_reg;
  assign jump_taken = taken_reg;

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  // Only the arithmetic unit writes it; a jump has no path into it
  always_comb begin
    sw_next = sw_reg;
    if (sw_we) begin
      sw_next = sw_wdata;
      if (sw_op_clears_v) begin
        sw_next[SW_V_BIT] = 1'b0;
      end
    end
  end

  // Status word register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sw_reg <= SW_RESET;
    end else begin
      sw_reg <= sw_next;
    end
  end

  assign status_word = sw_reg;

  // ---------------------------------------------------------------
  // Taken counter
  // ---------------------------------------------------------------
  wire logic cnt_inc = take_now & ctrl_reg[CTRL_COUNT_EN_BIT];  // Count enabled branches

  // Clear from software, but a branch in the same cycle still counts
  always_comb begin
    taken_cnt_next = taken_cnt_reg;
    if (ctrl_clear) begin
      taken_cnt_next = '0;
    end
    if (cnt_inc) begin
      taken_cnt_next = taken_cnt_next + 32'h1;
    end
  end

  // Counter register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      taken_cnt_reg <= '0;
    end else begin
      taken_cnt_reg <= taken_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  // Address and data are taken in either order and held until both exist
  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;

  wire logic aw_take  = s_axi_awvalid & s_axi_awready;  // Address taken
  wire logic w_take   = s_axi_wvalid & s_axi_wready;    // Data taken
  wire logic aw_have  = aw_hold_reg | aw_take;          // Address available
  wire logic w_have   = w_hold_reg | w_take;            // Data available
  wire logic wr_fire  = aw_have & w_have;               // Write happens now

  // Effective address and data of the write
  wire logic [AXI_AW-1:0] wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
  wire logic [AXI_DW-1:0] wr_data = w_hold_reg ? w_data_reg : s_axi_wdata;
  wire logic [3:0]        wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb;

  // Write decode
  wire logic wr_ctrl   = wr_fire & (wr_addr == REG_CTRL);
  wire logic wr_ro     = (wr_addr == REG_STATUS) | (wr_addr == REG_TARGET) | (wr_addr == REG_TAKEN);
  wire logic wr_mapped = (wr_addr == REG_CTRL) | wr_ro;
  wire logic ctrl_lane = wr_ctrl & wr_strb[0];                        // Control lives in lane 0
  assign ctrl_clear = ctrl_lane & wr_data[CTRL_CLEAR_BIT];            // Clear strobe

  // Capture of a lone address or lone data beat
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
    end else begin
      aw_hold_reg <= aw_have & ~wr_fire;
      w_hold_reg  <= w_have & ~wr_fire;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  // Response and control register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      ctrl_reg   <= CTRL_RESET;
    end else begin
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (ctrl_lane) begin
        ctrl_reg[CTRL_COUNT_EN_BIT] <= wr_data[CTRL_COUNT_EN_BIT];
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  assign s_axi_arready = ~rvalid_reg;

  wire logic ar_take = s_axi_arvalid & s_axi_arready;  // Read address taken

  // Read decode; narrow registers sit in the low bits
  wire logic rd_ctrl   = (s_axi_araddr == REG_CTRL);
  wire logic rd_status = (s_axi_araddr == REG_STATUS);
  wire logic rd_target = (s_axi_araddr == REG_TARGET);
  wire logic rd_taken  = (s_axi_araddr == REG_TAKEN);
  wire logic rd_mapped = rd_ctrl | rd_status | rd_target | rd_taken;

  wire logic [AXI_DW-1:0] rd_word =
    rd_ctrl   ? {{(AXI_DW-1){1'b0}}, ctrl_reg[CTRL_COUNT_EN_BIT]} :
    rd_status ? {{(AXI_DW-SW_W){1'b0}}, sw_reg} :
    rd_target ? {{(AXI_DW-PC_W){1'b0}}, pc_value_reg} :
    rd_taken  ? taken_cnt_reg : '0;

  // Read data register, answered one cycle after the address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else begin
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_word;
        rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

endmodule : cju_top
`default_nettype wire

/* sim/cju_top_props.sv */
`timescale 1ns/100ps
`default_nettype none
// Port checker of the jump unit
module cju_top_props import cju_pkg::*; (
  input wire logic             ref_clk,        // Clock
  input wire logic             rst,            // Reset
  input wire logic             jump_valid,     // Request
  input wire logic [2:0]       jump_kind,      // Kind
  input wire logic [OFS_W-1:0] jump_offset,    // Offset
  input wire logic [PC_W-1:0]  jump_pc_next,   // Next word
  input wire logic             pc_load,        // Load pulse
  input wire logic [PC_W-1:0]  pc_value,       // New PC
  input wire logic             jump_done,      // Done pulse
  input wire logic             jump_taken,     // Decision
  input wire logic             sw_we,          // Status write
  input wire logic             sw_op_clears_v, // V clearing op
  input wire logic [SW_W-1:0]  status_word     // Status word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [PC_W-1:0] tgt; // Relative target of the request
  logic            nxv; // N differs from V
  assign tgt = jump_pc_next + {{(PC_W-OFS_W-1){jump_offset[OFS_W-1]}}, jump_offset, 1'b0};
  assign nxv = status_word[SW_N_BIT] ^ status_word[SW_V_BIT];
  AST_CARRY: assert property (jump_valid && jump_kind == jump_on_carry |=>
    jump_taken == $past(status_word[SW_C_BIT])) else $error("carry decision wrong");
  AST_ZERO: assert property (jump_valid && jump_kind == jump_on_zero |=>
    jump_taken == $past(status_word[SW_Z_BIT])) else $error("zero decision wrong");
  AST_SGE: assert property (jump_valid && jump_kind == jump_signed_ge |=>
    jump_taken == !$past(nxv)) else $error("signed ge decision wrong");
  AST_SLT: assert property (jump_valid && jump_kind == jump_signed_lt |=>
    jump_taken == $past(nxv)) else $error("signed lt decision wrong");
  AST_NEG: assert property (jump_valid && jump_kind == jump_on_negative |=>
    jump_taken == $past(status_word[SW_N_BIT])) else $error("negative decision wrong");
  AST_ALWAYS: assert property (jump_valid && jump_kind == jump_always |=>
    pc_load && jump_done) else $error("unconditional jump not loaded");
  AST_LOAD: assert property (jump_valid |=> jump_done && pc_load == jump_taken)
    else $error("load pulse wrong");
  AST_TARGET: assert property (jump_valid |=>
    pc_value == (jump_taken ? $past(tgt) : $past(jump_pc_next))) else $error("pc value wrong");
  AST_HOLD: assert property (jump_valid && !sw_we |=> $stable(status_word))
    else $error("status word changed by jump");
  AST_VCLR: assert property (sw_we && sw_op_clears_v |=> !status_word[SW_V_BIT])
    else $error("overflow not cleared");
  C_GE: cover property (jump_valid && jump_kind == jump_signed_ge ##1 jump_taken);
  C_FALL: cover property (jump_done && !jump_taken);
  C_VCLR: cover property (sw_we && sw_op_clears_v);
endmodule : cju_top_props
bind cju_top cju_top_props u_cju_top_props (.ref_clk(ref_clk), .rst(rst),
  .jump_valid(jump_valid), .jump_kind(jump_kind), .jump_offset(jump_offset),
  .jump_pc_next(jump_pc_next), .pc_load(pc_load), .pc_value(pc_value), .jump_done(jump_done),
  .jump_taken(jump_taken), .sw_we(sw_we), .sw_op_clears_v(sw_op_clears_v), .status_word(status_word));
`default_nettype wire

/* sim/cju_fetch_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Fetch stage: follows each resolved jump
module cju_fetch_model import cju_pkg::*; (
  input  wire logic            ref_clk,   // Clock
  input  wire logic            rst,       // Reset
  input  wire logic            jump_done, // Jump resolved
  input  wire logic [PC_W-1:0] pc_value,  // Resolved address
  output logic      [PC_W-1:0] fetch_pc   // Next fetch address
);
  // Redirect on every resolution, taken or not
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fetch_pc <= PC_RESET;
    end else if (jump_done) begin
      fetch_pc <= pc_value;
    end
  end
endmodule : cju_fetch_model
`default_nettype wire

/* sim/cju_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// Bench of the jump unit
module cju_top_tb import cju_pkg::*; ;
  logic ref_clk = 1'b0, rst = 1'b1, jump_valid = 1'b0, sw_we = 1'b0, sw_op_clears_v = 1'b0;
  logic [2:0] jump_kind = 3'h0;
  logic [OFS_W-1:0] jump_offset = 10'h000;
  logic [PC_W-1:0] jump_pc_next = 20'h00000, pc_value, fetch_pc;
  logic [SW_W-1:0] sw_wdata = 16'h0000, sw_exp = 16'h0000, status_word;
  logic [AXI_AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [AXI_DW-1:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, pc_load, jump_done, jump_taken, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int n_mismatch = 0, comparisons = 0, cycles = 0, n_taken = 0;
  cju_top u_cju_top (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .jump_valid     (jump_valid),
    .jump_kind      (jump_kind),
    .jump_offset    (jump_offset),
    .jump_pc_next   (jump_pc_next),
    .pc_load        (pc_load),
    .pc_value       (pc_value),
    .jump_done      (jump_done),
    .jump_taken     (jump_taken),
    .sw_we          (sw_we),
    .sw_wdata       (sw_wdata),
    .sw_op_clears_v (sw_op_clears_v),
    .status_word    (status_word),
    .s_axi_awaddr   (s_axi_awaddr),
    .s_axi_awvalid  (s_axi_awvalid),
    .s_axi_awready  (s_axi_awready),
    .s_axi_wdata    (s_axi_wdata),
    .s_axi_wstrb    (s_axi_wstrb),
    .s_axi_wvalid   (s_axi_wvalid),
    .s_axi_wready   (s_axi_wready),
    .s_axi_bresp    (s_axi_bresp),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_bready   (s_axi_bready),
    .s_axi_araddr   (s_axi_araddr),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_rdata    (s_axi_rdata),
    .s_axi_rresp    (s_axi_rresp),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_rready   (s_axi_rready)
  );
  cju_fetch_model u_cju_fetch_model (.ref_clk(ref_clk), .rst(rst), .jump_done(jump_done),
    .pc_value(pc_value), .fetch_pc(fetch_pc));
  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // Expected decision per kind
  function automatic logic exp_taken(input int k, input logic [SW_W-1:0] s);
    case (k)
      jump_on_carry:    return s[SW_C_BIT];
      jump_on_zero:     return s[SW_Z_BIT];
      jump_signed_ge:   return !(s[SW_N_BIT] ^ s[SW_V_BIT]);
      jump_signed_lt:   return s[SW_N_BIT] ^ s[SW_V_BIT];
      jump_on_negative: return s[SW_N_BIT];
      jump_always:      return 1'b1;
      default:          return 1'b0;
    endcase
  endfunction : exp_taken
  task automatic set_sw(input logic [SW_W-1:0] d, input logic cv);
    @(posedge ref_clk);
    sw_we <= 1'b1;
    sw_wdata <= d;
    sw_op_clears_v <= cv;
    @(posedge ref_clk);
    sw_we <= 1'b0;
    sw_op_clears_v <= 1'b0;
    sw_exp = d;
    if (cv) sw_exp[SW_V_BIT] = 1'b0;
    #1;
    chk(status_word, sw_exp);
  endtask : set_sw
  task automatic do_jump(input logic [2:0] k, input logic [OFS_W-1:0] o, input logic [PC_W-1:0] p, input logic t);
    logic [PC_W-1:0] tgt;
    tgt = p + {{(PC_W-OFS_W-1){o[OFS_W-1]}}, o, 1'b0};
    @(posedge ref_clk);
    jump_valid <= 1'b1;
    jump_kind <= k;
    jump_offset <= o;
    jump_pc_next <= p;
    @(posedge ref_clk);
    jump_valid <= 1'b0;
    #1;
    n_taken += t;
    chk(jump_done, 1'b1);
    chk(jump_taken, t);
    chk(pc_load, t);
    chk(pc_value, t ? tgt : p);
    chk(status_word, sw_exp);
  endtask : do_jump
  task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [AXI_AW-1:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // Every kind against every flag mix, mode bits toggling
  task automatic t_flags();
    logic [SW_W-1:0] d;
    for (int i = 0; i < 16; i++) begin
      d = 16'h0000;
      {d[SW_V_BIT], d[SW_N_BIT], d[SW_Z_BIT], d[SW_C_BIT]} = i[3:0];
      {d[SW_GIE_BIT], d[SW_CPU_OFF_BIT_BIT], d[SW_OSCILLATOR_OFF_BIT_BIT]} = i[2:0] ^ i[3:1];
      set_sw(d, 1'b0);
      for (int k = 0; k < 8; k++) begin
        do_jump(k[2:0], 10'(i * 37 + k), 20'(i * 4096 + k * 2), exp_taken(k, d));
      end
    end
  endtask : t_flags
  // Reach limits, wrap, and the V-clearing path
  task automatic t_target();
    do_jump(jump_always, 10'h1ff, 20'h00400, 1'b1);
    chk(pc_value, 32'h007fe);
    do_jump(jump_always, 10'h200, 20'h00400, 1'b1);
    chk(pc_value, 32'h00000);
    do_jump(jump_always, 10'h001, 20'hffffe, 1'b1);
    chk(pc_value, 32'h00000);
    do_jump(jump_always, 10'h3ff, 20'h00000, 1'b1);
    @(posedge ref_clk);
    #1;
    chk(fetch_pc, 32'hffffe);
    set_sw(16'h0100, 1'b1);
    do_jump(jump_signed_ge, 10'h010, 20'h01000, 1'b1);
    set_sw(16'h0104, 1'b1);
    do_jump(jump_signed_ge, 10'h010, 20'h01000, 1'b0);
  endtask : t_target
  // Register view, clear, read-only and unmapped places
  task automatic t_regs();
    axi_rd(REG_STATUS);
    chk(rd, {16'h0000, sw_exp});
    axi_rd(REG_TARGET);
    chk(rd, 32'h00001000);
    axi_rd(REG_TAKEN);
    chk(rd, n_taken);
    axi_wr(REG_CTRL, 32'h00000002);
    chk(rsp, RESP_OKAY);
    do_jump(jump_always, 10'h004, 20'h00100, 1'b1);
    axi_rd(REG_TAKEN);
    chk(rd, 32'h00000000);
    axi_rd(REG_CTRL);
    chk(rd, 32'h00000000);
    axi_wr(REG_STATUS, 32'hffffffff);
    chk(rsp, RESP_OKAY);
    chk(status_word, sw_exp);
    axi_wr(8'h10, 32'h00000001);
    chk(rsp, RESP_SLVERR);
    axi_rd(8'h10);
    chk(rsp, RESP_SLVERR);
  endtask : t_regs
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(status_word, 16'h0000);
    chk(jump_done, 1'b0);
    t_flags();
    t_target();
    t_regs();
    end_of_test();
  end
endmodule : cju_top_tb
`default_nettype wire
